// *** include/t1_rx_sig_pkg.sv ***
/*
  constants and carrier types for the receive signaling / system highway
  block. assumes a single 100 MHz clock domain on the logic side.
*/
package t1_rx_sig_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int        NUM_CH        = 24;
  localparam int        RX_FIFO_DEPTH = 64;
  localparam logic [8:0] BITS_2M      = 9'h100;
  localparam logic [8:0] BITS_1M5     = 9'h0c1;
  localparam logic [4:0] MODE0_GAP    = 5'h04;
  localparam logic [4:0] MODE1_LAST   = 5'h18;
  // ----------------------------------------------------------------
  // multiframe positions
  // ----------------------------------------------------------------
  localparam logic [6:0] ROB_PERIOD   = 7'h06;
  localparam logic [6:0] ESF_MF_LEN   = 7'h18;
  localparam logic [6:0] F12_MF_LEN   = 7'h0c;
  localparam logic [6:0] DL_FIRST     = 7'h1a;
  localparam logic [6:0] DL_LAST      = 7'h48;
  localparam logic [6:0] DL_REG_FRAME = 7'h18;
  // ----------------------------------------------------------------
  // hdlc / message constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  FLAG_BYTE    = 8'h7e;
  localparam logic [7:0]  GROUP_ADDR_A = 8'hfe;
  localparam logic [7:0]  GROUP_ADDR_B = 8'hfc;
  localparam logic [7:0]  CR_MASK      = 8'hfd;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE  = 16'hf0b8;
  localparam logic [3:0]  ZERO_DEL_ONES = 4'h5;
  localparam logic [3:0]  ABORT_ONES   = 4'h7;
  localparam logic [3:0]  BOM_ONES     = 4'h8;
  localparam logic [14:0] BOM_MASK     = 15'h7f81;
  localparam logic [14:0] BOM_PATTERN  = 15'h7f00;
  // ----------------------------------------------------------------
  // fifo word kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_END  = 2'h1;
  localparam logic [1:0] KIND_BOM  = 2'h2;
  localparam logic [1:0] KIND_DL   = 2'h3;

  typedef struct packed {
    logic [4:0] ch;
    logic [6:0] frame;
    logic [7:0] data;
  } line_byte_t;

  typedef struct packed {
    logic [6:0] frame;
    logic       bit_val;
  } fbit_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] data;
  } fifo_word_t;

  typedef enum logic [2:0] {
    HUNT  = 3'b001,
    FRAME = 3'b010,
    BIT_ORIENTED_MESSAGE   = 3'b100
  } rx_state_t;
endpackage

// *** rtl/t1_rx_signaling_highway.sv ***
/*
  receive signaling controller and receive system highway, plus its
  signaling fifo. assumes line bytes and f-bits arrive from framer logic
  on sys_clk; highway clock and sync pulse arrive as asynchronous pins.
*/
`timescale 1ns/1ps

module rx_sig_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r, rd_r, wr_nxt, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_r];

  always_comb begin
    wr_nxt  = push ? AW'(wr_r + 1'b1) : wr_r;
    rd_nxt  = pop ? AW'(rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
endmodule

module t1_rx_signaling_highway #(
  parameter int FIFO_DEPTH = t1_rx_sig_pkg::RX_FIFO_DEPTH
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       line_valid,
  output      logic                       line_ready,
  input  wire t1_rx_sig_pkg::line_byte_t  line_in,
  input  wire logic                       fbit_valid,
  input  wire t1_rx_sig_pkg::fbit_t       fbit_in,
  input  wire logic                       rx_system_clock,
  input  wire logic                       rx_sync_pulse_n,
  input  wire logic [4:0]                 rx_offset_high,
  input  wire logic [2:0]                 rx_offset_low,
  input  wire logic                       rx_clock_rate_sel,
  input  wire logic                       translation_mode,
  input  wire logic                       frame_marker_enable,
  input  wire logic                       alarm_ones_insert,
  input  wire logic                       esf_format,
  input  wire logic                       f72_format,
  input  wire logic                       sig_fix_enable,
  input  wire logic                       sig_fix_level,
  input  wire logic                       frame_align_lost,
  input  wire logic                       multiframe_align_lost,
  input  wire logic                       signal_lost,
  input  wire logic                       rx_slip,
  input  wire logic                       hdlc_rx_enable,
  input  wire logic                       bom_rx_enable,
  input  wire logic                       bom_rx_mode_sel,
  input  wire logic                       transparent_mode,
  input  wire logic                       addr_check_enable,
  input  wire logic [7:0]                 high_addr_value_a,
  input  wire logic [7:0]                 high_addr_value_b,
  input  wire logic [23:0]                rx_slot_select,
  output      logic                       rx_data_out,
  output      logic                       rx_signaling_out,
  output      logic                       rx_frame_marker,
  output      logic                       freeze_output,
  output      logic                       signaling_change_irq,
  output      logic [95:0]                rx_signaling_regs,
  output      logic [23:0]                dl_regs,
  output      logic                       fifo_out_valid,
  input  wire logic                       fifo_out_ready,
  output      t1_rx_sig_pkg::fifo_word_t  fifo_out
);
  // ----------------------------------------------------------------
  // line side: frame store, robbed-bit signaling, freeze
  // ----------------------------------------------------------------
  logic [7:0]  frame_store [t1_rx_sig_pkg::NUM_CH];
  logic [3:0]  sig_stage   [t1_rx_sig_pkg::NUM_CH];
  logic [3:0]  sig_reg     [t1_rx_sig_pkg::NUM_CH];
  logic [7:0]  fsdl_r;
  logic        slip_hold_r, slip_hold_nxt, chg_r, chg_nxt;
  logic        commit_r, commit_nxt;
  logic        rob_frame, mf_end, lb_take;
  logic [6:0]  mf_len;
  logic [1:0]  rob_idx;
  logic [4:0]  ch_idx;
  logic        diff;

  assign lb_take   = line_valid && line_ready;
  assign ch_idx    = 5'(line_in.ch - 5'h01);
  assign mf_len    = esf_format ? t1_rx_sig_pkg::ESF_MF_LEN
                                : t1_rx_sig_pkg::F12_MF_LEN;
  assign rob_frame = (line_in.frame % t1_rx_sig_pkg::ROB_PERIOD) == 7'h00;
  assign rob_idx   = 2'((line_in.frame / t1_rx_sig_pkg::ROB_PERIOD) - 7'h01)
                     & (esf_format ? 2'h3 : 2'h1);
  assign mf_end    = (line_in.frame % mf_len) == 7'h00
                     && line_in.ch == 5'(t1_rx_sig_pkg::NUM_CH);
  assign freeze_output = frame_align_lost || multiframe_align_lost
                         || signal_lost || slip_hold_r;
  assign signaling_change_irq = chg_r;

  always_comb begin
    diff = 1'b0;
    for (int i = 0; i < t1_rx_sig_pkg::NUM_CH; i++) begin
      if (sig_stage[i] != sig_reg[i]) begin
        diff = 1'b1;
      end
    end
    slip_hold_nxt = rx_slip || (slip_hold_r && !(lb_take && mf_end));
    // commit a cycle late so the last robbed bit is in the stage
    commit_nxt = lb_take && mf_end && !freeze_output;
    chg_nxt = commit_r && !freeze_output && diff;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slip_hold_r <= 1'b0;
      chg_r       <= 1'b0;
      commit_r    <= 1'b0;
    end else begin
      slip_hold_r <= slip_hold_nxt;
      chg_r       <= chg_nxt;
      commit_r    <= commit_nxt;
    end
    if (lb_take) begin
      frame_store[ch_idx] <= line_in.data;
      if (rob_frame) begin
        sig_stage[ch_idx][3-rob_idx] <= line_in.data[0];
      end
    end
    if (fbit_valid) begin
      fsdl_r <= {fsdl_r[6:0], fbit_in.bit_val};
    end
  end

  genvar g;
  generate
    for (g = 0; g < t1_rx_sig_pkg::NUM_CH; g++) begin : g_sig
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          sig_reg[g] <= 4'h0;
        end else if (commit_r && !freeze_output) begin
          sig_reg[g] <= sig_stage[g];
        end
      end
      assign rx_signaling_regs[4*g +: 4] = sig_reg[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // system highway timing
  // ----------------------------------------------------------------
  logic [2:0] clk_s, syp_s;
  logic       tick, sync_hit;
  logic [8:0] pos_r, pos_nxt, frame_len, offset;
  logic       dout_r, dout_nxt, sout_r, sout_nxt, fm_r, fm_nxt;
  logic       is_fs, idle;
  logic [4:0] slot, chan;
  logic [2:0] bitn;
  logic [3:0] abcd;

  assign tick      = clk_s[2] && !clk_s[1];
  assign sync_hit  = syp_s[2] && !syp_s[1];
  assign frame_len = rx_clock_rate_sel ? t1_rx_sig_pkg::BITS_2M
                                       : t1_rx_sig_pkg::BITS_1M5;
  assign offset    = 9'({rx_offset_high, rx_offset_low}) % frame_len;
  assign rx_data_out      = dout_r;
  assign rx_signaling_out = sout_r;
  assign rx_frame_marker  = fm_r;

  always_comb begin
    is_fs = 1'b0;
    idle  = 1'b0;
    slot  = 5'h00;
    chan  = 5'h00;
    bitn  = 3'h0;
    if (rx_clock_rate_sel) begin
      slot = pos_r[7:3];
      bitn = pos_r[2:0];
      is_fs = (slot == 5'h00);
      if (translation_mode) begin
        idle = slot > t1_rx_sig_pkg::MODE1_LAST;
        chan = slot;
      end else begin
        idle = (slot % t1_rx_sig_pkg::MODE0_GAP) == 5'h00;
        chan = 5'(slot - slot / t1_rx_sig_pkg::MODE0_GAP);
      end
    end else begin
      is_fs = (pos_r == 9'h000);
      chan  = 5'((pos_r - 9'h001) / 9'h008 + 9'h001);
      bitn  = 3'(pos_r - 9'h001);
    end
    abcd = (chan != 5'h00 && !idle) ? sig_reg[5'(chan - 5'h01)] : 4'hf;
    if (!esf_format) begin
      abcd[1:0] = abcd[3:2];
    end
    if (sync_hit) begin
      pos_nxt = 9'((frame_len - offset) % frame_len);
    end else if (tick) begin
      pos_nxt = (pos_r == frame_len - 9'h001) ? 9'h000 : pos_r + 9'h001;
    end else begin
      pos_nxt = pos_r;
    end
    dout_nxt = dout_r;
    sout_nxt = sout_r;
    fm_nxt   = fm_r;
    if (tick) begin
      fm_nxt = frame_marker_enable && (pos_r == offset);
      if (alarm_ones_insert) begin
        dout_nxt = 1'b1;
        sout_nxt = 1'b1;
      end else if (is_fs) begin
        dout_nxt = rx_clock_rate_sel ? fsdl_r[3'h7 - bitn] : fsdl_r[0];
        sout_nxt = dout_nxt;
      end else if (idle) begin
        dout_nxt = 1'b1;
        sout_nxt = 1'b1;
      end else begin
        dout_nxt = frame_store[5'(chan - 5'h01)][3'h7 - bitn];
        if (bitn[2]) begin
          sout_nxt = abcd[2'h3 - bitn[1:0]];
        end else begin
          sout_nxt = sig_fix_enable ? sig_fix_level : dout_nxt;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_s  <= 3'h0;
      syp_s  <= 3'h7;
      pos_r  <= 9'h000;
      dout_r <= 1'b1;
      sout_r <= 1'b1;
      fm_r   <= 1'b0;
    end else begin
      clk_s  <= {clk_s[1:0], rx_system_clock};
      syp_s  <= {syp_s[1:0], rx_sync_pulse_n};
      pos_r  <= pos_nxt;
      dout_r <= dout_nxt;
      sout_r <= sout_nxt;
      fm_r   <= fm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // signaling controller bit engine
  // ----------------------------------------------------------------
  t1_rx_sig_pkg::rx_state_t st_r, st_nxt;
  t1_rx_sig_pkg::fifo_word_t push_word;
  logic [7:0]  sh_r, sh_nxt, hist_r, hist_nxt, db_r, db_nxt;
  logic [3:0]  shn_r, shn_nxt, ones_r, ones_nxt, dbn_r, dbn_nxt;
  logic [15:0] crc_r, crc_nxt;
  logic [14:0] bom_r, bom_nxt;
  logic [5:0]  bomv_r, bomv_nxt;
  logic        first_r, first_nxt, addr_ok;
  logic        push, push_ready, bit_v, step;
  logic [7:0]  dl_acc_r, dl_acc_nxt;
  logic [2:0]  dl_n_r, dl_n_nxt;
  logic        dl_push_r, dl_push_nxt;
  logic [23:0] dl_sh_r, dl_sh_nxt, dl_regs_nxt;

  function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ t1_rx_sig_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  assign line_ready = (shn_r == 4'h0) && push_ready && !dl_push_r;
  assign step       = (shn_r != 4'h0) && push_ready && !dl_push_r;
  assign bit_v      = sh_r[7];

  always_comb begin
    sh_nxt = sh_r;
    shn_nxt = shn_r;
    st_nxt = st_r;
    hist_nxt = hist_r;
    ones_nxt = ones_r;
    db_nxt = db_r;
    dbn_nxt = dbn_r;
    crc_nxt = crc_r;
    bom_nxt = bom_r;
    bomv_nxt = bomv_r;
    first_nxt = first_r;
    push = 1'b0;
    push_word = '{kind: t1_rx_sig_pkg::KIND_DATA, data: 8'h00};
    addr_ok = 1'b0;
    if (lb_take && rx_slot_select[ch_idx]) begin
      if (transparent_mode) begin
        push = 1'b1;
        push_word.data = line_in.data;
      end else if (hdlc_rx_enable || bom_rx_enable) begin
        sh_nxt = line_in.data;
        shn_nxt = 4'h8;
      end
    end else if (step) begin
      sh_nxt = {sh_r[6:0], 1'b0};
      shn_nxt = shn_r - 4'h1;
      hist_nxt = {hist_r[6:0], bit_v};
      ones_nxt = bit_v ? ((ones_r == 4'hf) ? ones_r : ones_r + 4'h1) : 4'h0;
      if (hist_nxt == t1_rx_sig_pkg::FLAG_BYTE) begin
        if (st_r == t1_rx_sig_pkg::FRAME && !first_r) begin
          push = 1'b1;
          push_word.kind = t1_rx_sig_pkg::KIND_END;
          push_word.data = {7'h00, crc_r == t1_rx_sig_pkg::CRC_RESIDUE};
        end
        st_nxt = hdlc_rx_enable ? t1_rx_sig_pkg::FRAME
                                : t1_rx_sig_pkg::BIT_ORIENTED_MESSAGE;
        crc_nxt = t1_rx_sig_pkg::CRC_INIT;
        dbn_nxt = 4'h0;
        first_nxt = 1'b1;
      end else if (ones_nxt >= t1_rx_sig_pkg::BOM_ONES && bom_rx_enable) begin
        st_nxt = t1_rx_sig_pkg::BIT_ORIENTED_MESSAGE;
        bom_nxt = {bom_r[13:0], bit_v};
      end else if (ones_nxt >= t1_rx_sig_pkg::ABORT_ONES
                   && st_r == t1_rx_sig_pkg::FRAME) begin
        st_nxt = t1_rx_sig_pkg::HUNT;
      end else if (st_r == t1_rx_sig_pkg::BIT_ORIENTED_MESSAGE) begin
        bom_nxt = {bom_r[13:0], bit_v};
        if ((bom_nxt & t1_rx_sig_pkg::BOM_MASK)
            == t1_rx_sig_pkg::BOM_PATTERN) begin
          bomv_nxt = bom_nxt[6:1];
          push = !bom_rx_mode_sel || (bom_nxt[6:1] == bomv_r);
          push_word.kind = t1_rx_sig_pkg::KIND_BOM;
          push_word.data = {2'h0, bom_nxt[6:1]};
          bom_nxt = 15'h0000;
        end
      end else if (st_r == t1_rx_sig_pkg::FRAME) begin
        if (!(ones_r == t1_rx_sig_pkg::ZERO_DEL_ONES && !bit_v)) begin
          db_nxt = {bit_v, db_r[7:1]};
          dbn_nxt = dbn_r + 4'h1;
          if (dbn_r == 4'h7) begin
            dbn_nxt = 4'h0;
            crc_nxt = crc_byte(crc_r, db_nxt);
            first_nxt = 1'b0;
            addr_ok = !addr_check_enable
              || (db_nxt & t1_rx_sig_pkg::CR_MASK)
                 == (t1_rx_sig_pkg::GROUP_ADDR_A & t1_rx_sig_pkg::CR_MASK)
              || (db_nxt & t1_rx_sig_pkg::CR_MASK)
                 == (t1_rx_sig_pkg::GROUP_ADDR_B & t1_rx_sig_pkg::CR_MASK)
              || (db_nxt & t1_rx_sig_pkg::CR_MASK)
                 == (high_addr_value_a & t1_rx_sig_pkg::CR_MASK)
              || (db_nxt & t1_rx_sig_pkg::CR_MASK)
                 == (high_addr_value_b & t1_rx_sig_pkg::CR_MASK);
            if (first_r && !addr_ok) begin
              st_nxt = t1_rx_sig_pkg::HUNT;
            end else begin
              push = 1'b1;
              push_word.data = db_nxt;
            end
          end
        end
      end
    end
    // f72 data link: registers per multiframe, later bits to the fifo
    dl_acc_nxt = dl_acc_r;
    dl_n_nxt = dl_n_r;
    dl_sh_nxt = dl_sh_r;
    dl_regs_nxt = dl_regs;
    dl_push_nxt = dl_push_r && !push_ready;
    if (fbit_valid && f72_format) begin
      dl_sh_nxt = {dl_sh_r[22:0], fbit_in.bit_val};
      if (fbit_in.frame == t1_rx_sig_pkg::DL_REG_FRAME) begin
        dl_regs_nxt = dl_sh_nxt;
      end
      if (fbit_in.frame >= t1_rx_sig_pkg::DL_FIRST
          && fbit_in.frame <= t1_rx_sig_pkg::DL_LAST) begin
        dl_acc_nxt = {dl_acc_r[6:0], fbit_in.bit_val};
        dl_n_nxt = dl_n_r + 3'h1;
        dl_push_nxt = (dl_n_r == 3'h7) || dl_push_nxt;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= t1_rx_sig_pkg::HUNT;
      sh_r <= 8'h00;
      shn_r <= 4'h0;
      hist_r <= 8'h00;
      ones_r <= 4'h0;
      db_r <= 8'h00;
      dbn_r <= 4'h0;
      crc_r <= t1_rx_sig_pkg::CRC_INIT;
      bom_r <= 15'h0000;
      bomv_r <= 6'h00;
      first_r <= 1'b1;
      dl_acc_r <= 8'h00;
      dl_n_r <= 3'h0;
      dl_push_r <= 1'b0;
      dl_sh_r <= 24'h000000;
      dl_regs <= 24'h000000;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      shn_r <= shn_nxt;
      hist_r <= hist_nxt;
      ones_r <= ones_nxt;
      db_r <= db_nxt;
      dbn_r <= dbn_nxt;
      crc_r <= crc_nxt;
      bom_r <= bom_nxt;
      bomv_r <= bomv_nxt;
      first_r <= first_nxt;
      dl_acc_r <= dl_acc_nxt;
      dl_n_r <= dl_n_nxt;
      dl_push_r <= dl_push_nxt;
      dl_sh_r <= dl_sh_nxt;
      dl_regs <= dl_regs_nxt;
    end
  end

  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  t1_rx_sig_pkg::fifo_word_t fifo_in;
  assign fifo_in = dl_push_r ? t1_rx_sig_pkg::fifo_word_t'{
                     kind: t1_rx_sig_pkg::KIND_DL, data: dl_acc_r}
                   : push_word;

  rx_sig_fifo #(
    .WIDTH ($bits(t1_rx_sig_pkg::fifo_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (push || dl_push_r),
    .in_ready  (push_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );
endmodule

// *** testbench/highway_partner.sv ***
/*
  backplane highway model: makes the highway clock and sync pulse and
  captures the outputs. assumes 256-bit frames at 6.25 mbit/s.
*/
`timescale 1ns/1ps
module highway_partner (
  output logic         hclk,
  output logic         sync_n,
  input  wire logic    data_in,
  input  wire logic    sig_in,
  input  wire logic    mark_in,
  output logic [255:0] cap,
  output logic [255:0] scap,
  output logic [255:0] mcap
);
  logic [7:0] pos;
  // backplane clock runs continuously, sync once per frame
  initial begin
    hclk = 1'b1;
    sync_n = 1'b1;
    pos = 8'h00;
    cap = '0;
    scap = '0;
    mcap = '0;
    forever #80 hclk = ~hclk;
  end
  always @(posedge hclk) sync_n <= (pos != 8'h00);
  always @(negedge hclk) begin
    cap[pos] <= data_in;
    scap[pos] <= sig_in;
    mcap[pos] <= mark_in;
    pos <= pos + 8'h01;
  end
endmodule

// *** testbench/rx_sig_assertions.sv ***
/*
  port checks for the receive signaling highway block.
  assumes one sys_clk domain with synchronous active-high rst.
*/
`timescale 1ns/1ps
module rx_sig_assertions #(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic                      sys_clk,
  input wire logic                      rst,
  input wire logic                      frame_marker_enable,
  input wire logic                      alarm_ones_insert,
  input wire logic                      frame_align_lost,
  input wire logic                      multiframe_align_lost,
  input wire logic                      signal_lost,
  input wire logic                      rx_data_out,
  input wire logic                      rx_signaling_out,
  input wire logic                      rx_frame_marker,
  input wire logic                      freeze_output,
  input wire logic                      signaling_change_irq,
  input wire logic [95:0]               rx_signaling_regs,
  input wire logic                      fifo_out_valid,
  input wire logic                      fifo_out_ready,
  input wire t1_rx_sig_pkg::fifo_word_t fifo_out
);
  logic [5:0] ais_cnt;
  always_ff @(posedge sys_clk) begin
    if (rst || !alarm_ones_insert) ais_cnt <= 6'h00;
    else if (ais_cnt != 6'h3f) ais_cnt <= ais_cnt + 6'h01;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  freeze_on_loss_a: assert property (
    (frame_align_lost || multiframe_align_lost || signal_lost)
    |-> freeze_output) else $error("freeze not raised");
  frozen_regs_a: assert property (
    freeze_output |=> $stable(rx_signaling_regs))
    else $error("registers moved while frozen");
  irq_pulse_a: assert property (
    signaling_change_irq |=> !signaling_change_irq)
    else $error("change pulse too long");
  irq_cause_a: assert property (
    !$stable(rx_signaling_regs) |-> ##[0:1] signaling_change_irq)
    else $error("register change without pulse");
  alarm_ones_a: assert property (
    ais_cnt >= 6'h28 |-> rx_data_out && rx_signaling_out)
    else $error("alarm ones missing");
  marker_width_a: assert property (
    $rose(rx_frame_marker) |=> rx_frame_marker[*8] ##1
    rx_frame_marker[*6] ##[1:3] !rx_frame_marker)
    else $error("marker not one bit long");
  marker_enable_a: assert property (
    $rose(rx_frame_marker) |-> $past(frame_marker_enable))
    else $error("marker while disabled");
  fifo_head_a: assert property (
    fifo_out_valid && !fifo_out_ready |=> fifo_out_valid && $stable(fifo_out))
    else $error("fifo head not held");
endmodule
bind t1_rx_signaling_highway rx_sig_assertions #(.FIFO_DEPTH(FIFO_DEPTH))
  chk (.*);

// *** testbench/test_t1_rx_signaling_highway.sv ***
/*
  bench for the receive signaling highway: line bytes in, highway,
  registers and fifo out. assumes the highway partner model.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  miscompares++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module test_t1_rx_signaling_highway;
  logic sys_clk, rst, line_valid, line_ready, fbit_valid, rx_slip;
  logic rx_system_clock, rx_sync_pulse_n, rx_clock_rate_sel;
  logic translation_mode, frame_marker_enable, alarm_ones_insert;
  logic esf_format, f72_format, sig_fix_enable, sig_fix_level;
  logic frame_align_lost, multiframe_align_lost, signal_lost;
  logic hdlc_rx_enable, bom_rx_enable, bom_rx_mode_sel, transparent_mode;
  logic addr_check_enable, rx_data_out, rx_signaling_out, rx_frame_marker;
  logic freeze_output, signaling_change_irq, fifo_out_valid, fifo_out_ready;
  logic [4:0]                rx_offset_high;
  logic [2:0]                rx_offset_low;
  logic [7:0]                high_addr_value_a, high_addr_value_b;
  logic [23:0]               rx_slot_select, dl_regs;
  logic [95:0]               rx_signaling_regs;
  logic [255:0]              cap, scap, mcap;
  t1_rx_sig_pkg::line_byte_t line_in;
  t1_rx_sig_pkg::fbit_t      fbit_in;
  t1_rx_sig_pkg::fifo_word_t fifo_out;
  int compares = 0, miscompares = 0, irqs = 0, n;
  t1_rx_signaling_highway #(.FIFO_DEPTH(4)) DUT (.*);
  highway_partner peer (.hclk(rx_system_clock), .sync_n(rx_sync_pulse_n),
    .data_in(rx_data_out), .sig_in(rx_signaling_out),
    .mark_in(rx_frame_marker), .cap(cap), .scap(scap), .mcap(mcap));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) if (signaling_change_irq === 1'b1) irqs++;
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic send(input int c, input int f, input logic [7:0] d);
    int w;
    w = 0;
    line_in = '{ch: 5'(c), frame: 7'(f), data: d};
    line_valid = 1'b1;
    while (line_ready !== 1'b1 && w < 80) begin
      cycles(1);
      w++;
    end
    if (w == 80) begin
      miscompares++;
      summarize;
    end
    cycles(1);
  endtask
  // one esf multiframe, abcd of channel c taken from c xor inv
  task automatic mf(input logic [3:0] inv);
    logic [3:0] x;
    for (int f = 1; f <= 24; f++)
      for (int c = 1; c <= 24; c++) begin
        x = 4'(c) ^ inv;
        send(c, f, {7'h00, (f % 6 == 0) ? x[f/6-1] : 1'b0});
      end
    line_valid = 1'b0;
    cycles(4);
  endtask
  function automatic logic [95:0] regs_exp(input logic [3:0] inv);
    logic [3:0] x;
    for (int c = 1; c <= 24; c++) begin
      x = 4'(c) ^ inv;
      regs_exp[4*(c-1) +: 4] = {x[0], x[1], x[2], x[3]};
    end
  endfunction
  // idle slots all ones, channel bits 0..6 zero, small latency allowed
  function automatic logic fits(input logic m1, input int off);
    logic ok, u;
    fits = 1'b0;
    for (int k = 0; k < 4; k++) begin
      ok = 1'b1;
      for (int i = 8; i < 256; i++) begin
        u = m1 ? (i >= 200) : (i % 32 < 8);
        if (u != cap[(i + off + k) % 256] && (u || i % 8 < 7)) ok = 1'b0;
      end
      if (ok) fits = 1'b1;
    end
  endfunction
  initial begin
    {fbit_valid, line_valid, translation_mode, alarm_ones_insert} = '0;
    {f72_format, sig_fix_enable, rx_slip, bom_rx_enable} = '0;
    {frame_align_lost, multiframe_align_lost, signal_lost} = '0;
    {bom_rx_mode_sel, addr_check_enable, fifo_out_ready} = '0;
    {hdlc_rx_enable, transparent_mode, line_in, fbit_in} = '0;
    {rx_offset_high, rx_offset_low, rx_slot_select} = '0;
    {high_addr_value_a, high_addr_value_b} = 16'h1012;
    {rst, esf_format, frame_marker_enable, sig_fix_level} = '1;
    rx_clock_rate_sel = 1'b1;
    cycles(8);
    rst = 1'b0;
    `CHK("data idle", 1'b1, rx_data_out)
    `CHK("regs idle", 96'h0, rx_signaling_regs)
    `CHK("fifo idle", 1'b0, fifo_out_valid)
    f72_format = 1'b1;
    for (int f = 1; f <= 24; f++) begin
      {fbit_valid, fbit_in} = {1'b1, 7'(f), f[0]};
      cycles(1);
    end
    fbit_valid = 1'b0;
    `CHK("dl regs", 24'haaaaaa, dl_regs)
    for (int i = 0; i < 3; i++) begin
      {frame_align_lost, multiframe_align_lost, signal_lost} = 3'(1 << i);
      cycles(1);
      `CHK("freeze", 1'b1, freeze_output)
    end
    {frame_align_lost, multiframe_align_lost, signal_lost, rx_slip} = 4'h1;
    cycles(1);
    rx_slip = 1'b0;
    cycles(3);
    `CHK("slip hold", 1'b1, freeze_output)
    mf(4'hd);
    `CHK("frozen regs", 96'h0, rx_signaling_regs)
    mf(4'h0);
    `CHK("robbed bits", regs_exp(4'h0), rx_signaling_regs)
    mf(4'h0);
    `CHK("change pulses", 1, irqs)
    {translation_mode, sig_fix_enable} = 2'b11;
    cycles(9000);
    `CHK("mode 1 slots", 1'b1, fits(1'b1, 0))
    `CHK("fs slot", 16'h5555, {cap[8:1], scap[8:1]})
    `CHK("sig slot 1", 8'h1f, scap[16:9])
    `CHK("marker at 0", 256'h2, mcap)
    translation_mode = 1'b0;
    {rx_offset_high, rx_offset_low} = 8'h0b;
    cycles(9000);
    `CHK("mode 0 slots", 1'b1, fits(1'b0, 11))
    `CHK("marker at 11", 256'h800000, mcap)
    {alarm_ones_insert, frame_marker_enable} = 2'b10;
    cycles(9000);
    `CHK("alarm ones", {256{1'b1}}, cap)
    `CHK("alarm sig", {256{1'b1}}, scap)
    {alarm_ones_insert, frame_marker_enable} = 2'b01;
    {hdlc_rx_enable, transparent_mode, rx_slot_select} = {2'b11, 24'h1};
    send(2, 1, 8'h11);
    for (int i = 0; i < 4; i++) send(1, 1, 8'ha0 + 8'(i));
    line_valid = 1'b0;
    cycles(20);
    `CHK("full refusal", 1'b0, line_ready)
    fifo_out_ready = 1'b1;
    n = 0;
    fork
      begin
        send(1, 1, 8'ha4);
        line_valid = 1'b0;
      end
      for (int w = 0; n < 5 && w < 300; w++) begin
        if (fifo_out_valid === 1'b1) begin
          `CHK("fifo word", {2'h0, 8'ha0 + 8'(n)}, fifo_out)
          n++;
        end
        cycles(1);
      end
    join
    `CHK("fifo words", 5, n)
    `CHK("fifo empty", 1'b0, fifo_out_valid)
    summarize;
  end
endmodule
